// ---- dblc_ctrl.sv ----
// module: display contrast and two-level backlight controller with identify flash
// ------------------------------------------------------------
// Summary of operation
// - contrast register accepts 0 to 9 and drives the contrast output
// - contrast 0 gives lightest characters, 9 darkest, graded between
// - contrast register resets to five
// - both backlight levels are writable from 0 to 9 in unit steps
// - button press or restart selects operating brightness
// - full timeout without presses selects standby brightness
// - buttons one to three restore operating brightness and restart the period
// - timeout accepts 60 to 9999 seconds, resets to 900
// - operating brightness from its own register, reset six
// - standby brightness from its own register, reset zero
// - brightness 0 minimum, 9 maximum, monotone between
// - identify request flashes backlight between maximum and minimum
// ------------------------------------------------------------
`timescale 1ns/100ps
module dblc_ctrl #(
    parameter int FLASH_HALF = dblc_pkg::FLASH_HALF_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        sec_tick,
    input  wire logic [2:0]  button,
    input  wire logic        identify,
    input  wire logic        reg_wr,
    input  wire logic [9:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             contrast_pwm,
    output logic             backlight_pwm,
    output logic [3:0]       backlight_level,
    output logic             standby_active
);
    // ------------------------------------------------------------
    // input synchronisers for pins
    // ------------------------------------------------------------
    logic [2:0] btn_s1, btn_s2, btn_s3;
    logic       id_s1, id_s2;

    always_ff @(posedge clock) begin
        if (rst) begin
            btn_s1 <= 3'h0;
            btn_s2 <= 3'h0;
            btn_s3 <= 3'h0;
            id_s1  <= 1'b0;
            id_s2  <= 1'b0;
        end else if (ce) begin
            btn_s1 <= button;
            btn_s2 <= btn_s1;
            btn_s3 <= btn_s2;
            id_s1  <= identify;
            id_s2  <= id_s1;
        end
    end

    // rising edge of any button restarts the period; a held button does not
    wire press = |(btn_s2 & ~btn_s3);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [15:0] contrast, oper_level, timeout, stby_level;

    function automatic logic level_ok(input logic [15:0] v);
        level_ok = (v <= dblc_pkg::LEVEL_MAX);
    endfunction

    wire wr_con  = reg_wr && (reg_addr == dblc_pkg::ADDR_CONTRAST)   && level_ok(reg_wdata);
    wire wr_oper = reg_wr && (reg_addr == dblc_pkg::ADDR_OPER_LEVEL) && level_ok(reg_wdata);
    wire wr_stby = reg_wr && (reg_addr == dblc_pkg::ADDR_STBY_LEVEL) && level_ok(reg_wdata);
    wire wr_tmo  = reg_wr && (reg_addr == dblc_pkg::ADDR_TIMEOUT)
                   && (reg_wdata >= dblc_pkg::TIMEOUT_MIN) && (reg_wdata <= dblc_pkg::TIMEOUT_MAX);

    // out-of-range writes are ignored, so the stored value always stays legal
    always_ff @(posedge clock) begin
        if (rst) begin
            contrast   <= dblc_pkg::RST_CONTRAST;
            oper_level <= dblc_pkg::RST_OPER_LEVEL;
            timeout    <= dblc_pkg::RST_TIMEOUT;
            stby_level <= dblc_pkg::RST_STBY_LEVEL;
        end else if (ce) begin
            if (wr_con)
                contrast <= reg_wdata;
            if (wr_oper)
                oper_level <= reg_wdata;
            if (wr_stby)
                stby_level <= reg_wdata;
            if (wr_tmo)
                timeout <= reg_wdata;
        end
    end

    wire [15:0] next_rdata = (reg_addr == dblc_pkg::ADDR_CONTRAST)   ? contrast   :
                             (reg_addr == dblc_pkg::ADDR_OPER_LEVEL) ? oper_level :
                             (reg_addr == dblc_pkg::ADDR_TIMEOUT)    ? timeout    :
                             (reg_addr == dblc_pkg::ADDR_STBY_LEVEL) ? stby_level : 16'h0000;

    always_ff @(posedge clock) begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (ce)
            reg_rdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // inactivity timer and mode
    // ------------------------------------------------------------
    logic [15:0]      idle_sec;
    dblc_pkg::dblc_mode_e mode;
    logic             stby;
    wire              expire = sec_tick && !stby && (idle_sec + 16'h0001 >= timeout);

    always_ff @(posedge clock) begin
        if (rst) begin
            idle_sec <= 16'h0000;
            stby     <= 1'b0;
        end else if (ce) begin
            if (press) begin
                idle_sec <= 16'h0000;
                stby     <= 1'b0;
            end else if (expire) begin
                stby     <= 1'b1;
            end else if (sec_tick && !stby) begin
                idle_sec <= idle_sec + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // identify flash timer
    // ------------------------------------------------------------
    logic [24:0] flash_cnt;
    logic        flash_hi;
    wire         flash_wrap = (flash_cnt == 25'(FLASH_HALF - 1));

    always_ff @(posedge clock) begin
        if (rst) begin
            flash_cnt <= 25'h0000000;
            flash_hi  <= 1'b1;
        end else if (ce) begin
            if (!id_s2) begin
                flash_cnt <= 25'h0000000;
                flash_hi  <= 1'b1;
            end else if (flash_wrap) begin
                flash_cnt <= 25'h0000000;
                flash_hi  <= !flash_hi;
            end else begin
                flash_cnt <= flash_cnt + 25'h0000001;
            end
        end
    end

    assign mode = id_s2 ? dblc_pkg::MODE_IDENT : (stby ? dblc_pkg::MODE_STBY : dblc_pkg::MODE_OPER);

    logic [3:0] sel_level;
    always_comb begin
        unique case (mode)
            dblc_pkg::MODE_OPER:  sel_level = oper_level[3:0];
            dblc_pkg::MODE_STBY:  sel_level = stby_level[3:0];
            dblc_pkg::MODE_IDENT: sel_level = flash_hi ? dblc_pkg::LEVEL_MAX4 : dblc_pkg::LEVEL_MIN4;
            default:              sel_level = oper_level[3:0];
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            backlight_level <= dblc_pkg::RST_OPER_LEVEL[3:0];
            standby_active  <= 1'b0;
        end else if (ce) begin
            backlight_level <= sel_level;
            standby_active  <= stby;
        end
    end

    // ------------------------------------------------------------
    // drive generators
    // ------------------------------------------------------------
    dblc_pwm u_contrast (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .level (contrast[3:0]),
        .pwm   (contrast_pwm)
    );

    dblc_pwm u_backlight (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .level (backlight_level),
        .pwm   (backlight_pwm)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_contrast_range: assert property (@(posedge clock) disable iff (rst)
        contrast <= dblc_pkg::LEVEL_MAX)
        else $error("contrast out of range");
    // reset checks look one edge on, so the first clock of the run never sees unset state
    a_contrast_reset: assert property (@(posedge clock)
        rst |=> contrast == dblc_pkg::RST_CONTRAST)
        else $error("contrast reset wrong");
    a_levels_range: assert property (@(posedge clock) disable iff (rst)
        oper_level <= dblc_pkg::LEVEL_MAX && stby_level <= dblc_pkg::LEVEL_MAX)
        else $error("level out of range");
    a_press_wakes: assert property (@(posedge clock) disable iff (rst)
        ce && press |=> !stby && idle_sec == 16'h0000)
        else $error("press did not wake");
    a_restart_oper: assert property (@(posedge clock)
        rst |=> !stby && idle_sec == 16'h0000)
        else $error("restart not operating");
    a_expire_stby: assert property (@(posedge clock) disable iff (rst)
        ce && expire && !press |=> stby)
        else $error("timeout not taken");
    a_idle_hold: assert property (@(posedge clock) disable iff (rst)
        ce && !press && !sec_tick |=> idle_sec == $past(idle_sec))
        else $error("idle count moved without tick");
    a_ce_freeze: assert property (@(posedge clock) disable iff (rst)
        !ce |=> $stable(idle_sec) && $stable(stby) && $stable(backlight_level))
        else $error("state moved with enable low");
    a_timeout_range: assert property (@(posedge clock) disable iff (rst)
        timeout >= dblc_pkg::TIMEOUT_MIN && timeout <= dblc_pkg::TIMEOUT_MAX)
        else $error("timeout out of range");
    a_oper_select: assert property (@(posedge clock) disable iff (rst)
        ce && !id_s2 && !stby |=> backlight_level == $past(oper_level[3:0]))
        else $error("operating level not used");
    a_stby_select: assert property (@(posedge clock) disable iff (rst)
        ce && !id_s2 && stby |=> backlight_level == $past(stby_level[3:0]))
        else $error("standby level not used");
    a_ident_first: assert property (@(posedge clock) disable iff (rst)
        ce && id_s2 && !$past(id_s2) |=> backlight_level == dblc_pkg::LEVEL_MAX4)
        else $error("identify did not start bright");
    a_ident_flash: assert property (@(posedge clock) disable iff (rst)
        ce && id_s2 |=> backlight_level == dblc_pkg::LEVEL_MAX4 || backlight_level == dblc_pkg::LEVEL_MIN4)
        else $error("identify level wrong");
    a_flash_toggle: assert property (@(posedge clock) disable iff (rst)
        ce && id_s2 && flash_wrap |=> flash_hi != $past(flash_hi))
        else $error("flash did not toggle");
endmodule // dblc_ctrl

// ---- dblc_panel_model.sv ----
// file: model of the operator push buttons and the network identify request
`timescale 1ns/100ps
module dblc_panel_model (
    input  wire logic clock,
    output logic [2:0] button,
    output logic       identify
);
    initial begin
        button   = 3'h0;
        identify = 1'b0;
    end
    // a press is held for four clocks so the two-flop sync sees it
    task automatic press(input int idx);
        @(negedge clock);
        button[idx] = 1'b1;
        repeat (4) @(negedge clock);
        button[idx] = 1'b0;
    endtask
    // identify is a level kept for as long as the flash is wanted
    task automatic ident(input logic on);
        @(negedge clock);
        identify = on;
    endtask
endmodule // dblc_panel_model

// ---- dblc_pkg.sv ----
// package: register map, reset values and timing constants of the display backlight and contrast control
package dblc_pkg;
    // ------------------------------------------------------------
    // register offsets (register index on the parameter port)
    // ------------------------------------------------------------
    localparam logic [9:0]  ADDR_CONTRAST   = 10'h023;
    localparam logic [9:0]  ADDR_OPER_LEVEL = 10'h024;
    localparam logic [9:0]  ADDR_TIMEOUT    = 10'h2EA;
    localparam logic [9:0]  ADDR_STBY_LEVEL = 10'h2EB;
    // ------------------------------------------------------------
    // reset values and setting ranges
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CONTRAST    = 16'h0005;
    localparam logic [15:0] RST_OPER_LEVEL  = 16'h0006;
    localparam logic [15:0] RST_TIMEOUT     = 16'h0384;
    localparam logic [15:0] RST_STBY_LEVEL  = 16'h0000;
    localparam logic [15:0] LEVEL_MAX       = 16'h0009;
    localparam logic [15:0] TIMEOUT_MIN     = 16'h003C;
    localparam logic [15:0] TIMEOUT_MAX     = 16'h270F;
    localparam logic [3:0]  LEVEL_MIN4      = 4'h0;
    localparam logic [3:0]  LEVEL_MAX4      = 4'h9;
    // ------------------------------------------------------------
    // pwm frame and identify flash timing
    // ------------------------------------------------------------
    localparam logic [3:0]  PWM_LAST        = 4'h8;
    localparam int          FLASH_HALF_MS   = 500;
    localparam int          CLK_HZ          = 25000000;
    localparam int          FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_HALF_MS;
    // ------------------------------------------------------------
    // backlight mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_OPER, MODE_STBY, MODE_IDENT} dblc_mode_e;
endpackage : dblc_pkg

// ---- dblc_pwm.sv ----
// module: ten-level pwm generator used for contrast and backlight drive
`timescale 1ns/100ps
module dblc_pwm (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [3:0] level,
    output logic            pwm
);
    logic [3:0] phase;
    wire        wrap = (phase == dblc_pkg::PWM_LAST);

    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= 4'h0;
            pwm   <= 1'b0;
        end else if (ce) begin
            phase <= wrap ? 4'h0 : phase + 4'h1;
            // duty is level/9: 0 fully off, 9 fully on, monotone between
            pwm   <= (phase < level);
        end
    end
endmodule // dblc_pwm

// ---- tb_top.sv ----
// file: self-checking testbench of the backlight and contrast controller
`timescale 1ns/100ps
module tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        sec_tick = 1'b0;
    logic        reg_wr = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [2:0]  button;
    logic        identify;
    logic [15:0] reg_rdata;
    logic        contrast_pwm;
    logic        backlight_pwm;
    logic [3:0]  backlight_level;
    logic        standby_active;
    int          err_count = 0;
    int          n_tests = 0;
    logic        seen_low;

    always #20 clock = ~clock;

    dblc_panel_model u_dblc_panel_model (.clock(clock), .button(button), .identify(identify));
    // short flash half period keeps the identify run brief
    dblc_ctrl #(.FLASH_HALF(4)) u_dblc_ctrl (.clock(clock), .rst(rst), .ce(ce), .sec_tick(sec_tick),
        .button(button), .identify(identify), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .contrast_pwm(contrast_pwm), .backlight_pwm(backlight_pwm),
        .backlight_level(backlight_level), .standby_active(standby_active));

    // ------------------------------------------------------------
    // access and check tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("mismatches %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(negedge clock);
        reg_addr = a;
        repeat (2) @(negedge clock);
        chk("reg_rdata", reg_rdata, e);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clock);
            sec_tick = 1'b1;
            @(negedge clock);
            sec_tick = 1'b0;
        end
    endtask
    // any nine consecutive clocks cover one whole pwm frame
    task automatic duty(input logic [15:0] eb, input logic [15:0] ec);
        logic [15:0] nb;
        logic [15:0] nc;
        nb = 16'h0000;
        nc = 16'h0000;
        repeat (9) begin
            @(negedge clock);
            nb += {15'h0000, backlight_pwm};
            nc += {15'h0000, contrast_pwm};
        end
        chk("backlight duty", nb, eb);
        chk("contrast duty", nc, ec);
    endtask
    task automatic lvl(input logic [3:0] el, input logic es);
        chk("backlight_level", {12'h000, backlight_level}, {12'h000, el});
        chk("standby_active", {15'h0000, standby_active}, {15'h0000, es});
    endtask

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        rd(dblc_pkg::ADDR_CONTRAST, 16'h0005);
        rd(dblc_pkg::ADDR_OPER_LEVEL, 16'h0006);
        rd(dblc_pkg::ADDR_TIMEOUT, 16'h0384);
        rd(dblc_pkg::ADDR_STBY_LEVEL, 16'h0000);
        rd(10'h025, 16'h0000);
        lvl(4'h6, 1'b0);
        duty(16'h0006, 16'h0005);
        wr(dblc_pkg::ADDR_CONTRAST, 16'h0009);
        wr(dblc_pkg::ADDR_CONTRAST, 16'h000A);
        rd(dblc_pkg::ADDR_CONTRAST, 16'h0009);
        wr(dblc_pkg::ADDR_OPER_LEVEL, 16'h000A);
        rd(dblc_pkg::ADDR_OPER_LEVEL, 16'h0006);
        wr(dblc_pkg::ADDR_OPER_LEVEL, 16'h0009);
        wr(dblc_pkg::ADDR_CONTRAST, 16'h0000);
        repeat (10) @(negedge clock);
        duty(16'h0009, 16'h0000);
        // clock enable low freezes the register file, so this write must not land
        ce = 1'b0;
        wr(dblc_pkg::ADDR_CONTRAST, 16'h0007);
        ce = 1'b1;
        rd(dblc_pkg::ADDR_CONTRAST, 16'h0000);
        wr(dblc_pkg::ADDR_TIMEOUT, 16'h003B);
        rd(dblc_pkg::ADDR_TIMEOUT, 16'h0384);
        wr(dblc_pkg::ADDR_TIMEOUT, 16'h270F);
        rd(dblc_pkg::ADDR_TIMEOUT, 16'h270F);
        wr(dblc_pkg::ADDR_TIMEOUT, 16'h2710);
        rd(dblc_pkg::ADDR_TIMEOUT, 16'h270F);
        wr(dblc_pkg::ADDR_TIMEOUT, 16'h003C);
        wr(dblc_pkg::ADDR_STBY_LEVEL, 16'h0003);
        rd(dblc_pkg::ADDR_STBY_LEVEL, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            u_dblc_panel_model.press(i);
            repeat (3) @(negedge clock);
            lvl(4'h9, 1'b0);
            ticks(59);
            lvl(4'h9, 1'b0);
            ticks(1);
            repeat (3) @(negedge clock);
            lvl(4'h3, 1'b1);
        end
        u_dblc_panel_model.ident(1'b1);
        repeat (4) @(negedge clock);
        chk("flash high", {12'h000, backlight_level}, 16'h0009);
        seen_low = 1'b0;
        for (int k = 0; k < 12 && !seen_low; k++) begin
            @(negedge clock);
            seen_low = (backlight_level === 4'h0);
        end
        chk("flash low", {15'h0000, seen_low}, 16'h0001);
        if (!seen_low) end_sim();
        u_dblc_panel_model.ident(1'b0);
        repeat (4) @(negedge clock);
        lvl(4'h3, 1'b1);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        lvl(4'h6, 1'b0);
        rd(dblc_pkg::ADDR_CONTRAST, 16'h0005);
        end_sim();
    end
endmodule // tb_top
